// ### verilog/dmacc_pkg.sv
// package for the dma channel control block: register map, fields, types
// Notes on behaviour
// [RULE_01] control bit 15 high enables the channel, low keeps it disabled
// [RULE_02] size bit one moves a byte per transfer, zero a 16-bit word
// [RULE_03] direction one reads dma ram, writes peripheral; zero the reverse
// [RULE_04] half bit raises block interrupt at half block, else at full block
// [RULE_05] null-write also writes null data to peripheral; software keeps dir 0
// [RULE_06] addressing mode: 00 post-inc, 01 no inc, 10 peripheral indirect, 11 reserved
// [RULE_07] mode: 00 continuous, 01 one-shot, 10 continuous ping-pong, 11 one-shot ping-pong
// [RULE_08] one-shot ping-pong does one primary block, one secondary block, then stops
// [RULE_09] setting manual trigger forces one transfer without a peripheral request
// [RULE_10] hardware clears manual trigger on completion; software cannot clear it
// [RULE_11] with manual trigger clear, selected peripheral request starts each transfer
// [RULE_12] seven-bit request select picks one of 128 request lines
// [RULE_13] sixteen-bit primary start address is the dma ram buffer address
// [RULE_14] sixteen-bit secondary start address used when ping-pong selects it
// [RULE_15] sixteen-bit peripheral address used on the peripheral side of transfers
// [RULE_16] software must not write peripheral address or count while enabled
// [RULE_17] a block holds one more transfer than the ten-bit count field
// [RULE_18] unimplemented register bits read as zero
// [RULE_19] a per-channel interrupt request pulses on each block completion; the code gives none there while the half bit is set
// [RULE_20] continuous mode reloads the start address after each block
// [RULE_21] ping-pong flag reads one while secondary start address is in use
// [RULE_22] a disabled channel ignores requests and manual trigger
package dmacc_pkg;

  localparam logic [7:0] dmacc_off_ctrl  = 8'h00;
  localparam logic [7:0] dmacc_off_req   = 8'h04;
  localparam logic [7:0] dmacc_off_sta   = 8'h08;
  localparam logic [7:0] dmacc_off_stb   = 8'h0c;
  localparam logic [7:0] dmacc_off_pad   = 8'h10;
  localparam logic [7:0] dmacc_off_cnt   = 8'h14;
  localparam logic [7:0] dmacc_off_stat  = 8'h18;

  localparam int dmacc_bit_on    = 15;
  localparam int dmacc_bit_size  = 14;
  localparam int dmacc_bit_dir   = 13;
  localparam int dmacc_bit_half  = 12;
  localparam int dmacc_bit_null_peripheral_write = 11;
  localparam int dmacc_bit_force = 15;

  localparam logic [15:0] dmacc_ctrl_mask = 16'hf833;
  localparam logic [15:0] dmacc_req_mask  = 16'h007f;
  localparam logic [15:0] dmacc_cnt_mask  = 16'h03ff;
  localparam logic [15:0] dmacc_rst_val   = 16'h0000;

  typedef enum logic [1:0] {
    dmacc_am_postinc = 2'b00,
    dmacc_am_noinc   = 2'b01,
    dmacc_am_perind  = 2'b10,
    dmacc_am_rsvd    = 2'b11
  } dmacc_addressing_mode_t;

  typedef enum logic [1:0] {
    dmacc_op_cont    = 2'b00,
    dmacc_op_once    = 2'b01,
    dmacc_op_cont_pp = 2'b10,
    dmacc_op_once_pp = 2'b11
  } dmacc_opmode_t;

  typedef enum logic [1:0] {
    dmacc_st_idle = 2'b00,
    dmacc_st_xfer = 2'b01,
    dmacc_st_wait = 2'b11
  } dmacc_state_t;

  // one request to the transfer bus
  typedef struct packed {
    logic        valid;
    logic        ram_to_per;
    logic        byte_size;
    logic        null_write;
    logic [15:0] ram_addr;
    logic [15:0] per_addr;
  } dmacc_xfer_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } dmacc_ahb_rsp_t;

endpackage

// ### verilog/dmacc_top.sv
// dma channel control: registers over ahb-lite and the transfer sequencer
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
module dmacc_top #(
  parameter int req_lines = 128
) (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic                   hsel,
  input  wire logic [7:0]             haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output      dmacc_pkg::dmacc_ahb_rsp_t ahb_rsp,
  input  wire logic [req_lines-1:0]   request_lines,
  input  wire logic                   xfer_done,
  output      dmacc_pkg::dmacc_xfer_t xfer,
  output      logic                   block_irq,
  output      logic                   pingpong_select_flag
);
  import dmacc_pkg::*;

  typedef struct packed {
    logic [15:0]    ctrl;
    logic [15:0]    req;
    logic [15:0]    primary_start;
    logic [15:0]    stb;
    logic [15:0]    pad;
    logic [15:0]    cnt;
    logic           wr_pend;
    logic [7:0]     addr;
    dmacc_ahb_rsp_t rsp;
    dmacc_state_t   state;
    logic [9:0]     done_cnt;
    logic [15:0]    ram_ptr;
    logic           pp;
    logic           pp_first_done;
    logic           forced;
    logic           half_sent;
    dmacc_xfer_t    xfer;
    logic           irq;
    logic [req_lines-1:0] rq_s1;
    logic [req_lines-1:0] rq_s2;
    logic [req_lines-1:0] rq_s3;
  } dmacc_regs_t;

  dmacc_regs_t cur_ff;
  dmacc_regs_t nxt_ff;

  logic          channel_on;
  logic [6:0]    request_source_select;
  logic [9:0]    transfer_count_field;
  logic [1:0]    addressing_mode;
  logic [1:0]    opmode;
  logic          channel_trigger;
  logic [15:0]   wdata16;
  logic          addr_phase;
  logic [15:0]   rd16;
  logic          last_xfer;
  logic [9:0]    half_point;

  assign channel_on            = cur_ff.ctrl[dmacc_bit_on];     // [RULE_01]
  assign request_source_select = cur_ff.req[6:0];
  assign transfer_count_field  = cur_ff.cnt[9:0];
  assign addressing_mode       = cur_ff.ctrl[5:4];
  assign opmode                = cur_ff.ctrl[1:0];
  assign wdata16               = hwdata[15:0];
  assign addr_phase            = hsel & htrans[1] & hready;
  // rising edge of the selected, synchronised request line
  assign channel_trigger = cur_ff.rq_s2[request_source_select]
                         & ~cur_ff.rq_s3[request_source_select]; // [RULE_12]
  assign last_xfer  = (cur_ff.done_cnt == transfer_count_field); // [RULE_17]
  assign half_point = transfer_count_field >> 1;

  ////////////////////////////////////////////////////////////////////////
  // read mux looked up on the address phase so data stands in data phase
  always_comb begin
    rd16 = 16'h0000;
    unique case (haddr)
      dmacc_off_ctrl: rd16 = cur_ff.ctrl & dmacc_ctrl_mask;       // [RULE_18]
      dmacc_off_req:  rd16 = cur_ff.req & (dmacc_req_mask | 16'h8000);
      dmacc_off_sta:  rd16 = cur_ff.primary_start;
      dmacc_off_stb:  rd16 = cur_ff.stb;
      dmacc_off_pad:  rd16 = cur_ff.pad;
      dmacc_off_cnt:  rd16 = cur_ff.cnt & dmacc_cnt_mask;
      dmacc_off_stat: rd16 = {15'h0000, cur_ff.pp};               // [RULE_21]
      default:        rd16 = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.rq_s1 = request_lines;
    nxt_ff.rq_s2 = cur_ff.rq_s1;
    nxt_ff.rq_s3 = cur_ff.rq_s2;
    nxt_ff.irq = 1'b0;
    nxt_ff.rsp.hreadyout = 1'b1;
    nxt_ff.rsp.hresp = 1'b0;
    nxt_ff.rsp.hrdata = 32'h0000_0000;

    // bus data phase: writes land here, reads answer here
    if (cur_ff.wr_pend) begin
      unique case (cur_ff.addr)
        dmacc_off_ctrl: nxt_ff.ctrl = wdata16 & dmacc_ctrl_mask;
        dmacc_off_req: begin
          nxt_ff.req[6:0] = wdata16[6:0];
          // software can set but never clear the manual trigger
          if (wdata16[dmacc_bit_force])
            nxt_ff.req[dmacc_bit_force] = 1'b1;                    // [RULE_10]
        end
        dmacc_off_sta: nxt_ff.primary_start = wdata16;                        // [RULE_13]
        dmacc_off_stb: nxt_ff.stb = wdata16;                        // [RULE_14]
        dmacc_off_pad: nxt_ff.pad = wdata16;                        // [RULE_15]
        dmacc_off_cnt: nxt_ff.cnt = wdata16 & dmacc_cnt_mask;
        default: ;
      endcase
    end
    nxt_ff.wr_pend = addr_phase & hwrite;
    if (addr_phase)
      nxt_ff.addr = haddr;
    if (addr_phase & ~hwrite)
      nxt_ff.rsp.hrdata = {16'h0000, rd16};

    // channel being switched on starts a fresh primary block
    if (cur_ff.wr_pend && cur_ff.addr == dmacc_off_ctrl
        && wdata16[dmacc_bit_on] && !channel_on) begin
      nxt_ff.pp = 1'b0;
      nxt_ff.pp_first_done = 1'b0;
      nxt_ff.done_cnt = 10'h000;
      nxt_ff.half_sent = 1'b0;
      nxt_ff.ram_ptr = cur_ff.primary_start;
      nxt_ff.state = dmacc_st_idle;
    end else if (!channel_on) begin
      nxt_ff.state = dmacc_st_idle;                                 // [RULE_22]
      nxt_ff.xfer.valid = 1'b0;
    end else begin
      unique case (cur_ff.state)
        dmacc_st_idle: begin
          if (cur_ff.req[dmacc_bit_force] || channel_trigger) begin // [RULE_09] [RULE_11]
            nxt_ff.forced = cur_ff.req[dmacc_bit_force];
            nxt_ff.xfer.valid = 1'b1;
            nxt_ff.xfer.ram_to_per = cur_ff.ctrl[dmacc_bit_dir];    // [RULE_03]
            nxt_ff.xfer.byte_size = cur_ff.ctrl[dmacc_bit_size];    // [RULE_02]
            nxt_ff.xfer.null_write = cur_ff.ctrl[dmacc_bit_null_peripheral_write]
                                   & ~cur_ff.ctrl[dmacc_bit_dir];   // [RULE_05]
            nxt_ff.xfer.per_addr = cur_ff.pad;                      // [RULE_15]
            // peripheral indirect takes the offset from the peripheral side
            nxt_ff.xfer.ram_addr = (addressing_mode == dmacc_am_perind)
                                 ? cur_ff.ram_ptr | cur_ff.pad
                                 : cur_ff.ram_ptr;                  // [RULE_06]
            nxt_ff.state = dmacc_st_xfer;
          end
        end
        dmacc_st_xfer: begin
          if (xfer_done) begin
            nxt_ff.xfer.valid = 1'b0;
            nxt_ff.state = dmacc_st_wait;
            if (cur_ff.forced)
              nxt_ff.req[dmacc_bit_force] = 1'b0;                   // [RULE_10]
            if (addressing_mode == dmacc_am_postinc)
              nxt_ff.ram_ptr = cur_ff.ram_ptr
                + (cur_ff.ctrl[dmacc_bit_size] ? 16'h0001 : 16'h0002);
            if (cur_ff.ctrl[dmacc_bit_half] && !cur_ff.half_sent
                && cur_ff.done_cnt == half_point) begin
              nxt_ff.irq = 1'b1;                                    // [RULE_04]
              nxt_ff.half_sent = 1'b1;
            end
            if (last_xfer) begin
              nxt_ff.irq = ~cur_ff.ctrl[dmacc_bit_half];            // [RULE_19]
              nxt_ff.done_cnt = 10'h000;
              nxt_ff.half_sent = 1'b0;
              unique case (opmode)                                  // [RULE_07]
                dmacc_op_cont: nxt_ff.ram_ptr = cur_ff.primary_start;         // [RULE_20]
                dmacc_op_once: nxt_ff.ctrl[dmacc_bit_on] = 1'b0;
                dmacc_op_cont_pp: begin
                  nxt_ff.pp = ~cur_ff.pp;                           // [RULE_21]
                  nxt_ff.ram_ptr = cur_ff.pp ? cur_ff.primary_start : cur_ff.stb;
                end
                dmacc_op_once_pp: begin
                  if (cur_ff.pp_first_done) begin
                    nxt_ff.ctrl[dmacc_bit_on] = 1'b0;               // [RULE_08]
                  end else begin
                    nxt_ff.pp_first_done = 1'b1;
                    nxt_ff.pp = 1'b1;
                    nxt_ff.ram_ptr = cur_ff.stb;                    // [RULE_14]
                  end
                end
              endcase
            end else begin
              nxt_ff.done_cnt = cur_ff.done_cnt + 10'h001;
            end
          end
        end
        dmacc_st_wait: nxt_ff.state = dmacc_st_idle;
        default: nxt_ff.state = dmacc_st_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur_ff <= '0;
      cur_ff.rsp.hreadyout <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign ahb_rsp              = cur_ff.rsp;
  assign xfer                 = cur_ff.xfer;
  assign block_irq            = cur_ff.irq;
  assign pingpong_select_flag = cur_ff.pp;

endmodule

// ### verification/dmacc_checker.sv
// port-level assertion checker for the dma channel control block
`timescale 1ns/10ps
module dmacc_checker (
  input wire logic                 clock,
  input wire logic                 sys_rst,
  input dmacc_pkg::dmacc_ahb_rsp_t ahb_rsp,
  input wire logic                 xfer_done,
  input dmacc_pkg::dmacc_xfer_t    xfer,
  input wire logic                 block_irq,
  input wire logic                 pingpong_select_flag
);
  import dmacc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_upper_zero: assert property (ahb_rsp.hrdata[31:16] == 16'h0000)
    else $error("upper read data bits not zero");
  a_irq_cause: assert property (
    block_irq |-> $past(xfer_done) && !xfer.valid)
    else $error("block interrupt without a finished transfer");
  a_irq_single: assert property (block_irq |=> !block_irq)
    else $error("block interrupt longer than one cycle");
  a_xfer_hold: assert property (
    xfer.valid && !xfer_done |=> xfer.valid && $stable(xfer))
    else $error("transfer request changed before completion");
  a_xfer_gap: assert property (
    xfer.valid && xfer_done |=> !xfer.valid [*2])
    else $error("transfer request too soon after completion");
  a_flag_quiet: assert property (
    $changed(pingpong_select_flag) |-> !xfer.valid)
    else $error("buffer flag moved during a transfer");
  a_bus_ready: assert property (ahb_rsp.hreadyout)
    else $error("bus wait state inserted");
  a_bus_okay: assert property (!ahb_rsp.hresp)
    else $error("bus error response");
endmodule
////////////////////////////////////////////////////////////////////////////
bind dmacc_top dmacc_checker u_chk (
  .clock(clock), .sys_rst(sys_rst), .ahb_rsp(ahb_rsp),
  .xfer_done(xfer_done), .xfer(xfer), .block_irq(block_irq),
  .pingpong_select_flag(pingpong_select_flag));

// ### verification/dmacc_xfer_partner.sv
// transfer bus model: finishes each request after a set latency
`timescale 1ns/10ps
module dmacc_xfer_partner (
  input wire logic              clock,
  input wire logic              sys_rst,
  input dmacc_pkg::dmacc_xfer_t xfer,
  input wire logic [7:0]        lat,
  output logic                  xfer_done
);
  import dmacc_pkg::*;
  int cnt;
  always @(posedge clock) begin
    if (sys_rst || !xfer.valid || xfer_done) begin
      cnt <= 0;
      xfer_done <= 1'b0;
    end else if (cnt >= lat) begin
      xfer_done <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// ### verification/dma_channel_control_test.sv
// self-checking bench for the dma channel control block
`timescale 1ns/10ps
module dma_channel_control_test;
  import dmacc_pkg::*;
  logic           clock, sys_rst, hsel, hwrite, hready, xfer_done;
  logic           block_irq, pingpong_select_flag;
  logic [7:0]     haddr, lat;
  logic [1:0]     htrans;
  logic [2:0]     hsize;
  logic [31:0]    hwdata, r;
  logic [127:0]   request_lines;
  dmacc_ahb_rsp_t ahb_rsp;
  dmacc_xfer_t    xfer;
  int             mismatches, compares;

  assign hready = ahb_rsp.hreadyout;
  always #2 clock = ~clock;

  dmacc_top uut (.clock(clock), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .ahb_rsp(ahb_rsp),
    .request_lines(request_lines), .xfer_done(xfer_done), .xfer(xfer),
    .block_irq(block_irq), .pingpong_select_flag(pingpong_select_flag));
  dmacc_xfer_partner peer (.clock(clock), .sys_rst(sys_rst),
    .xfer(xfer), .lat(lat), .xfer_done(xfer_done));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clock); while (ahb_rsp.hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (ahb_rsp.hreadyout !== 1'b1);
    q = ahb_rsp.hrdata;
  endtask

  task automatic pulse(input logic [6:0] s);
    request_lines[s] <= 1'b1;
    repeat (3) @(posedge clock);
    request_lines[s] <= 1'b0;
  endtask

  task automatic idle_check();
    repeat (8) begin
      @(posedge clock);
      #1;
      chk(xfer.valid, 0);
    end
  endtask

  // one channel setup, nb blocks of n+1 transfers, then a disabled check
  task automatic scen(input logic [15:0] c, input int n, input int nb,
                      input int f, input logic [7:0] l);
    logic [6:0]  s;
    logic [15:0] a, b, p, base, er;
    int          step, e;
    s = 7'($urandom);
    a = 16'($urandom);
    b = 16'($urandom);
    p = 16'($urandom);
    lat <= l;
    request_lines <= {$urandom, $urandom, $urandom, $urandom}
                     & ~(128'h1 << s);
    bus(1, dmacc_off_ctrl, 0, r);
    bus(1, dmacc_off_sta, a, r);
    bus(1, dmacc_off_stb, b, r);
    bus(1, dmacc_off_pad, p, r);
    bus(1, dmacc_off_cnt, n, r);
    bus(1, dmacc_off_req, s, r);
    bus(1, dmacc_off_ctrl, c | 16'h07cc, r);
    step = c[14] ? 1 : 2;
    for (int k = 0; k < nb; k++) begin
      base = (c[1] && k[0]) ? b : a;
      for (int i = 0; i <= n; i++) begin
        if (f != 0) bus(1, dmacc_off_req, 32'h8000 | s, r);
        else pulse(s);
        e = 0;
        do begin
          @(posedge clock);
          #1;
          e++;
        end while (xfer.valid !== 1'b1 && e < 40);
        er = c[5] ? (base | p) : (c[4] ? base : 16'(base + i * step));
        chk(xfer.valid, 1);
        chk(xfer.ram_addr, er);
        chk(xfer.per_addr, p);
        chk({xfer.byte_size, xfer.ram_to_per, xfer.null_write},
            {c[14], c[13], c[11]});
        chk(pingpong_select_flag, c[1] & k[0]);
        if (f != 0 && i == 0) begin
          bus(1, dmacc_off_req, s, r);
          bus(0, dmacc_off_req, 0, r);
          chk(r, 32'h8000 | s);
        end
        do @(posedge clock); while (xfer_done !== 1'b1);
        #1;
        chk(block_irq, c[12] ? i == n / 2 : i == n);
        if (f != 0) begin
          bus(0, dmacc_off_req, 0, r);
          chk(r, s);
        end
        repeat (2) @(posedge clock);
      end
    end
    bus(0, dmacc_off_ctrl, 0, r);
    chk(r, c & (c[0] ? 16'h7fff : 16'hffff));
    bus(1, dmacc_off_ctrl, 0, r);
    pulse(s);
    idle_check();
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {clock, hsel, hwrite, htrans, haddr, hwdata, request_lines} = '0;
    {sys_rst, hsize, lat, mismatches, compares} = {1'b1, 3'b010, 8'h0, 64'h0};
    void'($urandom(32'h7d7babf9));
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    for (int o = 0; o <= 8'h1c; o += 4) begin
      bus(0, 8'(o), 0, r);
      chk(r, 0);
    end
    scen(16'h8000, 2, 2, 0, 8'd0);
    scen(16'he011, 1, 1, 1, 8'd12);
    scen(16'h9822, 3, 2, 0, 8'd3);
    scen(16'h8003, 1, 2, 1, 8'd12);
    bus(1, dmacc_off_req, 32'h8000, r);
    idle_check();
    tally_and_finish();
  end
endmodule
